// *** uss_pkg.sv ***
// package: register map, field positions and reset values of the synchronous slave serial port
package uss_pkg;
    // ============================================================
    // bus geometry
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 32;
    localparam int          WORD_BITS     = 8;
    localparam int          FIFO_DEPTH    = 2;
    // ============================================================
    // register indexes and byte addresses (byte address = 4 * index)
    localparam logic [7:0]  IDX_FLAGS     = 8'h0C;
    localparam logic [7:0]  IDX_RXSTAT    = 8'h18;
    localparam logic [7:0]  IDX_TXHOLD    = 8'h19;
    localparam logic [7:0]  IDX_RXBUF     = 8'h1A;
    localparam logic [7:0]  IDX_ENABLES   = 8'h8C;
    localparam logic [7:0]  IDX_TXSTAT    = 8'h98;
    localparam logic [7:0]  IDX_BAUD      = 8'h99;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS   = {IDX_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RXSTAT  = {IDX_RXSTAT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TXHOLD  = {IDX_TXHOLD, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RXBUF   = {IDX_RXBUF, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ENABLES = {IDX_ENABLES, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TXSTAT  = {IDX_TXSTAT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_BAUD    = {IDX_BAUD, 2'b00};
    // ============================================================
    // field positions
    localparam int          B_RX_AVAIL    = 5;
    localparam int          B_TX_FLAG     = 4;
    localparam int          B_PORT_EN     = 7;
    localparam int          B_RX9_SEL     = 6;
    localparam int          B_SINGLE_RX   = 5;
    localparam int          B_CONT_RX     = 4;
    localparam int          B_ADDR_DET    = 3;
    localparam int          B_FRAME_ERR   = 2;
    localparam int          B_OVERRUN     = 1;
    localparam int          B_RX9_VAL     = 0;
    localparam int          B_CLK_SRC     = 7;
    localparam int          B_TX9_SEL     = 6;
    localparam int          B_TX_EN       = 5;
    localparam int          B_SYNC_SEL    = 4;
    localparam int          B_HIGH_BAUD   = 2;
    localparam int          B_SHIFT_EMPTY = 1;
    localparam int          B_TX9_VAL     = 0;
    // ============================================================
    // reset values and bus answers
    localparam logic [7:0]  RST_FLAGS     = 8'h00;
    localparam logic [7:0]  RST_RXSTAT    = 8'h00;
    localparam logic [7:0]  RST_TXSTAT    = 8'h02;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} uss_tx_state_t;
endpackage

// *** uss_usart_sync_slave.sv ***
// synchronous slave serial port with an axi4-lite register slave
`timescale 1ns/10ps
module uss_usart_sync_slave #(
    parameter int FIFO_DEPTH = uss_pkg::FIFO_DEPTH
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [uss_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [uss_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [uss_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [uss_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       clock_line_pin_in,
    output logic                            clock_line_pin_out,
    output logic                            clock_line_pin_oe,
    input  wire logic                       data_line_pin_in,
    output logic                            data_line_pin_out,
    output logic                            data_line_pin_oe,
    output logic                            irq_request
);
    import uss_pkg::*;

    // ============================================================
    // declarations
    logic                ck_s1_reg, ck_s2_reg, ck_s3_reg, dt_s1_reg, dt_s2_reg;
    logic                aw_held_reg, w_held_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [ADDR_W-1:0]   aw_addr_reg;
    logic [7:0]          w_data_reg;
    logic                w_strb_reg;
    logic [1:0]          bresp_reg, rresp_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic [7:0]          rxstat_reg, txstat_reg, enables_reg, baud_reg;
    logic                overrun_reg;
    logic [8:0]          hold_reg, tsr_reg, rsr_reg;
    logic                hold_full_reg, tx_flag_reg, rx_done_reg, irq_reg;
    logic [3:0]          tx_cnt_reg, rx_cnt_reg;
    uss_tx_state_t       tx_state_reg;
    logic [8:0]          fifo_mem_reg [FIFO_DEPTH];
    logic                head_reg;
    logic [1:0]          count_reg, count_next;
    logic                dout_reg, doe_reg;
    logic                ck_fall, slave_on, rx_on, tx_on, wr_do, ar_fire, pop, push, tail;
    logic                wr_transmit_holding, tx_last, rx_last, load_hold, rx_avail, rx9_head;
    logic [3:0]          nbits_tx, nbits_rx;
    logic [7:0]          rd_byte;
    logic                rd_ok, wr_ok;

    // ============================================================
    // pin synchronisers and clock edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_s3_reg <= 1'b0;
            dt_s1_reg <= 1'b0;
            dt_s2_reg <= 1'b0;
        end else begin
            ck_s1_reg <= clock_line_pin_in;
            ck_s2_reg <= ck_s1_reg;
            ck_s3_reg <= ck_s2_reg;
            dt_s1_reg <= data_line_pin_in;
            dt_s2_reg <= dt_s1_reg;
        end
    end
    assign ck_fall  = ck_s3_reg & ~ck_s2_reg;
    assign slave_on = rxstat_reg[B_PORT_EN] & txstat_reg[B_SYNC_SEL] & ~txstat_reg[B_CLK_SRC];
    assign rx_on    = slave_on & rxstat_reg[B_CONT_RX];
    assign tx_on    = slave_on & txstat_reg[B_TX_EN] & ~rxstat_reg[B_CONT_RX];
    assign nbits_tx = txstat_reg[B_TX9_SEL] ? 4'h9 : 4'h8;
    assign nbits_rx = rxstat_reg[B_RX9_SEL] ? 4'h9 : 4'h8;

    // ============================================================
    // axi write channel
    assign wr_do    = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_ok    = aw_addr_reg inside {ADDR_FLAGS, ADDR_RXSTAT, ADDR_TXHOLD, ADDR_RXBUF,
                                          ADDR_ENABLES, ADDR_TXSTAT, ADDR_BAUD};
    assign wr_transmit_holding = wr_do & w_strb_reg & (aw_addr_reg == ADDR_TXHOLD);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_addr_reg <= '0;
            w_data_reg  <= 8'h00;
            w_strb_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                aw_held_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_held_reg <= 1'b1;
                wready_reg <= 1'b0;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // ============================================================
    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxstat_reg  <= RST_RXSTAT;
            txstat_reg  <= RST_TXSTAT;
            enables_reg <= RST_FLAGS;
            baud_reg    <= RST_BYTE;
        end else if (wr_do && w_strb_reg) begin
            case (aw_addr_reg)
                ADDR_RXSTAT:  rxstat_reg  <= w_data_reg & 8'hF8;
                ADDR_TXSTAT:  txstat_reg  <= w_data_reg & 8'hF5;
                ADDR_ENABLES: enables_reg <= w_data_reg & 8'h30;
                ADDR_BAUD:    baud_reg    <= w_data_reg;
                default:      baud_reg    <= baud_reg;
            endcase
        end
    end

    // ============================================================
    // axi read channel
    always_comb begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        case (s_axi_araddr)
            ADDR_FLAGS:   rd_byte = {2'b00, rx_avail, tx_flag_reg, 4'h0};
            ADDR_RXSTAT:  rd_byte = {rxstat_reg[7:3], 1'b0, overrun_reg, rx9_head};
            ADDR_TXHOLD:  rd_byte = 8'h00;
            ADDR_RXBUF:   rd_byte = count_reg != 2'd0 ? fifo_mem_reg[head_reg][7:0] : 8'h00;
            ADDR_ENABLES: rd_byte = enables_reg;
            ADDR_TXSTAT:  rd_byte = {txstat_reg[7:2], tx_state_reg == TX_IDLE, txstat_reg[0]};
            ADDR_BAUD:    rd_byte = baud_reg;
            default:      rd_ok   = 1'b0;
        endcase
    end
    assign ar_fire = s_axi_arvalid & arready_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= {24'h000000, rd_byte};
            rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // ============================================================
    // receive shifter
    assign rx_last = rx_on & ck_fall & (rx_cnt_reg == nbits_rx - 4'h1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_cnt_reg  <= 4'h0;
            rsr_reg     <= 9'h000;
            rx_done_reg <= 1'b0;
        end else begin
            rx_done_reg <= rx_last;
            if (!rx_on) begin
                rx_cnt_reg <= 4'h0;
            end else if (ck_fall) begin
                rsr_reg[rx_cnt_reg] <= dt_s2_reg;
                rx_cnt_reg <= rx_last ? 4'h0 : rx_cnt_reg + 4'h1;
            end
        end
    end

    // ============================================================
    // two-deep receive queue and overrun
    assign pop       = ar_fire & (s_axi_araddr == ADDR_RXBUF) & (count_reg != 2'd0);
    assign push      = rx_done_reg & ~overrun_reg & ((count_reg != 2'd2) | pop);
    assign tail      = head_reg ^ count_reg[0];
    assign rx_avail  = count_reg != 2'd0;
    assign rx9_head  = rx_avail & fifo_mem_reg[head_reg][8];
    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head_reg  <= 1'b0;
            count_reg <= 2'd0;
            fifo_mem_reg[0] <= 9'h000;
            fifo_mem_reg[1] <= 9'h000;
        end else begin
            if (push) begin
                fifo_mem_reg[tail] <= {rxstat_reg[B_RX9_SEL] & rsr_reg[8], rsr_reg[7:0]};
            end
            if (pop) begin
                head_reg <= ~head_reg;
            end
            count_reg <= count_next;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_reg <= 1'b0;
        end else if (rx_done_reg && count_reg == 2'd2 && !pop) begin
            overrun_reg <= 1'b1;
        end else if (!rxstat_reg[B_CONT_RX]) begin
            overrun_reg <= 1'b0;
        end
    end

    // ============================================================
    // transmit holding register and shifter
    assign tx_last   = (tx_state_reg == TX_SHIFT) & ck_fall & (tx_cnt_reg == nbits_tx - 4'h1);
    assign load_hold = tx_on & hold_full_reg & ((tx_state_reg == TX_IDLE) | tx_last);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_reg      <= 9'h000;
            hold_full_reg <= 1'b0;
        end else if (wr_transmit_holding) begin
            hold_reg      <= {txstat_reg[B_TX9_VAL], w_data_reg};
            hold_full_reg <= 1'b1;
        end else if (load_hold) begin
            hold_full_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_reg <= TX_IDLE;
            tsr_reg      <= 9'h000;
            tx_cnt_reg   <= 4'h0;
        end else if (!tx_on) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= 4'h0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (load_hold) begin
                        tsr_reg      <= hold_reg;
                        tx_cnt_reg   <= 4'h0;
                        tx_state_reg <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (load_hold) begin
                        tsr_reg    <= hold_reg;
                        tx_cnt_reg <= 4'h0;
                    end else if (tx_last) begin
                        tx_state_reg <= TX_IDLE;
                    end else if (ck_fall) begin
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // ============================================================
    // flags, interrupt request and pin drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_flag_reg <= 1'b0;
            irq_reg     <= 1'b0;
            dout_reg    <= 1'b1;
            doe_reg     <= 1'b0;
        end else begin
            tx_flag_reg <= txstat_reg[B_TX_EN] & ~hold_full_reg;
            irq_reg     <= (rx_avail & enables_reg[B_RX_AVAIL]) |
                           (tx_flag_reg & enables_reg[B_TX_FLAG]);
            dout_reg    <= (tx_state_reg == TX_SHIFT) ? tsr_reg[tx_cnt_reg] : 1'b1;
            doe_reg     <= tx_on & (tx_state_reg == TX_SHIFT);
        end
    end

    assign s_axi_awready      = awready_reg;
    assign s_axi_wready       = wready_reg;
    assign s_axi_bvalid       = bvalid_reg;
    assign s_axi_bresp        = bresp_reg;
    assign s_axi_arready      = arready_reg;
    assign s_axi_rvalid       = rvalid_reg;
    assign s_axi_rdata        = rdata_reg;
    assign s_axi_rresp        = rresp_reg;
    assign data_line_pin_out  = dout_reg;
    assign data_line_pin_oe   = doe_reg;
    assign clock_line_pin_out = 1'b0;
    assign clock_line_pin_oe  = 1'b0;
    assign irq_request        = irq_reg;

    // ============================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    clk_never_driven_a: assert property (!clock_line_pin_oe)
        else $error("clock pin driven");
    data_drive_a: assert property (data_line_pin_oe |-> $past(tx_on) && $past(tx_state_reg) == TX_SHIFT)
        else $error("data pin driven outside a transmission");
    slave_off_a: assert property (!slave_on |=> tx_state_reg == TX_IDLE && rx_cnt_reg == 4'h0)
        else $error("shifting while not in slave mode");
    rx_complete_a: assert property (rx_last |=> rx_done_reg ##1 (rx_avail || overrun_reg))
        else $error("completed word not delivered");
    overrun_set_a: assert property (rx_done_reg && count_reg == 2'd2 && !pop |=> overrun_reg && count_reg == 2'd2)
        else $error("third word did not raise overrun");
    overrun_clear_a: assert property (!rxstat_reg[B_CONT_RX] && !rx_done_reg |=> !overrun_reg)
        else $error("overrun not cleared by receive disable");
    queue_blocked_a: assert property (overrun_reg |=> count_reg <= $past(count_reg))
        else $error("queue grew while overrun set");
    tx_held_a: assert property (tx_on && tx_state_reg == TX_SHIFT && hold_full_reg && !tx_last
                                |=> ##1 !tx_flag_reg)
        else $error("buffer flag set while word still held");
    tx_reload_a: assert property (load_hold && tx_state_reg == TX_SHIFT && !wr_transmit_holding
                                  |=> tx_state_reg == TX_SHIFT && tx_cnt_reg == 4'h0 ##1 tx_flag_reg)
        else $error("held word not reloaded before flag set");
    rx_irq_a: assert property (rx_avail && enables_reg[B_RX_AVAIL] |=> irq_request)
        else $error("receive interrupt not raised");

    push_c: cover property (push);
    overrun_c: cover property (rx_done_reg && count_reg == 2'd2);
    reload_c: cover property (load_hold && tx_state_reg == TX_SHIFT);
    pop_c: cover property (pop ##1 rx_avail);
endmodule // uss_usart_sync_slave

// *** uss_far_master.sv ***
// far-side synchronous master model that drives the shift clock
`timescale 1ns/10ps
module uss_far_master (
    output logic      ck,
    output logic      drv,
    output logic      val,
    input  wire logic line
);
    logic [8:0] got;
    initial begin
        ck = 1'b1;
        drv = 1'b0;
        val = 1'b0;
    end
    // ============================================================
    // one frame, bit0 first; clock stands still between frames
    task automatic frame(input logic [8:0] d, input int n, input logic send);
        for (int i = 0; i < n; i++) begin
            drv <= send;
            val <= d[i];
            #40 ck <= 1'b0;
            got[i] = line;
            #40 ck <= 1'b1;
        end
        drv <= 1'b0;
    endtask
endmodule // uss_far_master

// *** tb_top.sv ***
// self-checking bench of the synchronous slave serial port
`timescale 1ns/10ps
module tb_top;
    import uss_pkg::*;
    logic              aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic              ck_out, ck_oe, d_out, d_oe, irq, ck, drv, val;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, rv;
    logic [1:0]        bresp, rresp, resp;
    logic [8:0]        mq[$];
    logic [7:0]        tv[2];
    int                failures = 0, checks = 0;
    wire               dline = d_oe ? d_out : (drv ? val : ~val);
    uss_usart_sync_slave i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clock_line_pin_in(ck), .clock_line_pin_out(ck_out), .clock_line_pin_oe(ck_oe),
        .data_line_pin_in(dline), .data_line_pin_out(d_out), .data_line_pin_oe(d_oe), .irq_request(irq));
    uss_far_master i_far (.ck(ck), .drv(drv), .val(val), .line(dline));
    initial begin
        forever #5 aclk = ~aclk;
    end
    // ============================================================
    // bus tasks and comparison
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic pa = 1'b1;
        logic pw = 1'b1;
        @(posedge aclk);
        awaddr <= {ix, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready === 1'b1) awvalid <= 1'b0;
            if (pw && wready === 1'b1) wvalid <= 1'b0;
            pa = pa && (awready !== 1'b1);
            pw = pw && (wready !== 1'b1);
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ix);
        @(posedge aclk);
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [7:0] ix, input logic [31:0] e);
        rd(ix);
        chk(nm, e, rv);
    endtask
    // frame into the port, mirrored in the queue model
    task automatic rx(input logic [8:0] d, input int n, input logic on);
        i_far.frame(d, n, 1'b1);
        repeat (4) @(posedge aclk);
        if (on && mq.size() == 2) begin
            rd(IDX_RXSTAT);
            chk("overrun", 32'h1, {31'h0, rv[B_OVERRUN]});
        end else if (on) begin
            mq.push_back({d[8] & (n == 9), d[7:0]});
        end
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        summarize();
    end
    // ============================================================
    // main sequence
    initial begin
        void'($urandom(80053));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc("flags", IDX_FLAGS, 32'h0);
        rc("rx status", IDX_RXSTAT, 32'h0);
        rc("tx status", IDX_TXSTAT, 32'h2);
        rc("enables", IDX_ENABLES, 32'h0);
        rd(8'h01);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(IDX_ENABLES, 8'h30);
        chk("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        rc("enables", IDX_ENABLES, 32'h30);
        wr(IDX_TXSTAT, 8'h10);
        wr(IDX_RXSTAT, 8'hE0);
        rx(9'($urandom), 9, 1'b0);
        rc("flags", IDX_FLAGS, 32'h0);
        wr(IDX_RXSTAT, 8'hD0);
        for (int i = 0; i < 3; i++) rx(9'($urandom), 9, 1'b1);
        rc("flags", IDX_FLAGS, 32'h20);
        chk("irq", 32'h1, {31'h0, irq});
        for (int i = 0; i < 2; i++) begin
            rc("rx status", IDX_RXSTAT, {24'h0, 8'hD2 | mq[0][8]});
            rc("rx buffer", IDX_RXBUF, {24'h0, mq[0][7:0]});
            void'(mq.pop_front());
        end
        rc("flags", IDX_FLAGS, 32'h0);
        wr(IDX_RXSTAT, 8'h80);
        rd(IDX_RXSTAT);
        chk("overrun", 32'h0, {31'h0, rv[B_OVERRUN]});
        wr(IDX_TXSTAT, 8'h71);
        rc("flags", IDX_FLAGS, 32'h10);
        tv[0] = 8'($urandom);
        tv[1] = 8'($urandom);
        wr(IDX_TXHOLD, tv[0]);
        wr(IDX_TXHOLD, tv[1]);
        rc("flags", IDX_FLAGS, 32'h0);
        for (int i = 0; i < 2; i++) begin
            i_far.frame(9'h0, 9, 1'b0);
            chk("tx word", {23'h0, 1'b1, tv[i]}, {23'h0, i_far.got});
            repeat (4) @(posedge aclk);
            rc("flags", IDX_FLAGS, 32'h10);
        end
        chk("irq", 32'h1, {31'h0, irq});
        // internal clock source: slave port must ignore the master's frame
        wr(IDX_TXSTAT, 8'hF1);
        wr(IDX_RXSTAT, 8'h90);
        rx(9'($urandom), 8, 1'b0);
        rc("flags", IDX_FLAGS, 32'h10);
        // eight-bit reception in slave mode
        wr(IDX_TXSTAT, 8'h10);
        rx(9'($urandom), 8, 1'b1);
        rc("rx status", IDX_RXSTAT, {24'h0, 8'h90 | mq[0][8]});
        rc("rx buffer", IDX_RXBUF, {24'h0, mq[0][7:0]});
        void'(mq.pop_front());
        chk("pin drive", 32'h0, {29'h0, ck_out, ck_oe, d_oe});
        summarize();
    end
endmodule // tb_top
